//--- inc/clvc_consts.vh
// register map, field positions, reset values and timing of the valve loop controller
`ifndef CLVC_CONSTS_VH
`define CLVC_CONSTS_VH
`define CLVC_A_CTRL 4'h0
`define CLVC_A_KP 4'h1
`define CLVC_A_KI 4'h2
`define CLVC_A_KD 4'h3
`define CLVC_A_RUP 4'h4
`define CLVC_A_RDN 4'h5
`define CLVC_A_FIX 4'h6
`define CLVC_A_WIN 4'h7
`define CLVC_A_SCALE 4'h8
`define CLVC_A_STAT 4'h9
`define CLVC_A_CMD 4'ha
`define CLVC_A_RIDX 4'hb
`define CLVC_A_REC0 4'hc
`define CLVC_A_REC1 4'hd
`define CLVC_A_REC2 4'he
`define CLVC_A_REC3 4'hf
`define CLVC_LAST_CFG 4'h8
`define CLVC_B_LOOP 0
`define CLVC_B_DMODE 1
`define CLVC_B_TWO 2
`define CLVC_B_BIPOL 3
`define CLVC_B_SPCUR 4
`define CLVC_B_SPOFS 5
`define CLVC_B_ACTOFS 6
`define CLVC_B_CBM 7
`define CLVC_B_REACT 8
`define CLVC_B_REC 9
`define CLVC_B_SAVE 0
`define CLVC_B_LOAD 1
`define CLVC_RST_CTRL 16'h0001
`define CLVC_RST_KP 16'h0040
`define CLVC_RST_WIN 16'h0100
`define CLVC_RST_SCALE 16'h0100
`define CLVC_ADC_OFS 10'h0cd
`define CLVC_CB_CODE 10'h066
`define CLVC_CLK_HZ 20000000
`define CLVC_CB_TIME_MS 100
`define CLVC_RAMP_TICK_US 1000
`endif

//--- rtl/clvc_ctrl.v
// closed-loop valve controller: set-point path, ramps, pid, supervision, registers, recorder
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "clvc_consts.vh"
// Notes on behaviour
// - control difference is ramped set-point minus actual; current follows from it
// - pid loop with software gains kp, ki, kd
// - set-point generator ramps the internal set-point before the controller
// - separate linear up and down ramp steps, zero to about 8380 s span
// - loop off bit makes the block a plain amplifier of the set-point
// - digital output selectable as fault or target-reached indicator
// - target mode: output high while enabled and actual lies within window of set-point
// - no solenoid current while enable is low
// - enable input is active high
// - fault mode: output active whenever an error has been detected
// - error latch clears only on enable going low then high again
// - 10-bit samples; offset current range uses a reduced code span
// - cable break on current set-point blocks solenoids and raises the fault
// - cable-break check only with supervision on and 4-20 current input
// - break recognised after about 100 ms of low input
// - error reaction: block, or fixed current where the error permits it
// - set-point taken from voltage or current input by a control bit
// - bipolar voltage only with two solenoids, else a configuration error
// - feedback range: voltage, full-scale current or offset current
// - parameters saved to and restored from non-volatile storage
// - one scale factor maps set-point and actual to user units
// - recorder keeps set-point, actual, difference and current on each sample
// - two solenoids: negative drives b, positive drives a, by magnitude
module clvc_ctrl #(
  parameter CB_CYC = `CLVC_CB_TIME_MS * (`CLVC_CLK_HZ / 1000),
  parameter RAMP_CYC = `CLVC_RAMP_TICK_US * (`CLVC_CLK_HZ / 1000000)
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output wire [15:0] reg_rdata_o,
  input wire enable_i,
  input wire adc_valid_i,
  input wire [9:0] sp_volt_i,
  input wire [9:0] sp_curr_i,
  input wire [9:0] act_i,
  output wire [11:0] sol_a_o,
  output wire [11:0] sol_b_o,
  output wire dout_o,
  output wire nvm_we_o,
  output wire nvm_re_o,
  output wire [3:0] nvm_addr_o,
  output wire [15:0] nvm_wdata_o,
  input wire [15:0] nvm_rdata_i
);
  localparam [20:0] CB_LAST = CB_CYC[20:0] - 21'h000001;
  localparam [14:0] RT_LAST = RAMP_CYC[14:0] - 15'h0001;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_SAVE = 3'b100;

  function [15:0] clvc_rst;
    input [3:0] idx;
    begin
      case (idx)
        `CLVC_A_CTRL: clvc_rst = `CLVC_RST_CTRL;
        `CLVC_A_KP: clvc_rst = `CLVC_RST_KP;
        `CLVC_A_WIN: clvc_rst = `CLVC_RST_WIN;
        `CLVC_A_SCALE: clvc_rst = `CLVC_RST_SCALE;
        default: clvc_rst = 16'h0000;
      endcase
    end
  endfunction

  // adc code to 0..32736; offset range loses the codes below 4 ma
  function [15:0] clvc_norm;
    input [9:0] code;
    input ofs;
    reg [10:0] d;
    begin
      d = {1'b0, code} - {1'b0, `CLVC_ADC_OFS};
      if (!ofs)
        clvc_norm = {1'b0, code, 5'h00};
      else if (d[10])
        clvc_norm = 16'h0000;
      else
        clvc_norm = {6'h00, d[9:0]} * 16'h0028;
    end
  endfunction

  function [15:0] clvc_scale;
    input [15:0] u;
    input [15:0] g;
    reg [31:0] p;
    begin
      p = u * g;
      if (|p[31:23])
        clvc_scale = 16'h7fff;
      else
        clvc_scale = p[23:8];
    end
  endfunction

  function [15:0] clvc_sat;
    input signed [35:0] v;
    begin
      if (v > 36'sh007fff)
        clvc_sat = 16'h7fff;
      else if (v < -36'sh007fff)
        clvc_sat = 16'h8001;
      else
        clvc_sat = v[15:0];
    end
  endfunction

  reg [15:0] cfg_q [0:8];
  reg [63:0] rec_mem [0:15];
  reg [2:0] st_q;
  reg [3:0] idx_q;
  reg nre_q;
  reg nwe_q;
  reg [3:0] naddr_q;
  reg [15:0] nwd_q;
  reg ldv_q;
  reg [3:0] ldi_q;
  reg [15:0] rdata_q;
  reg [15:0] rdata_d;
  reg [3:0] ridx_q;
  reg [3:0] wp_q;
  reg en_s1_q;
  reg en_s2_q;
  reg en_s3_q;
  reg en_q;
  reg en_p_q;
  reg [20:0] cb_cnt_q;
  reg cb_q;
  reg err_lat_q;
  reg blk_lat_q;
  reg [14:0] rt_cnt_q;
  reg signed [24:0] ramp_q;
  reg signed [15:0] integ_q;
  reg signed [15:0] e_prev_q;
  reg signed [15:0] cmd_q;
  reg [11:0] sol_a_q;
  reg [11:0] sol_b_q;
  reg dout_q;
  reg tgt_q;
  integer i;

  wire [15:0] ctrl = cfg_q[`CLVC_A_CTRL];
  wire [15:0] gain = cfg_q[`CLVC_A_SCALE];
  wire two = ctrl[`CLVC_B_TWO];
  wire sp_cur = ctrl[`CLVC_B_SPCUR];
  wire run = en_q & st_q[0];
  wire en_rise = en_q & ~en_p_q;
  wire rtick = (rt_cnt_q == RT_LAST);
  wire cfg_wr = reg_we_i & (reg_addr_i <= `CLVC_LAST_CFG);
  wire cmd_wr = reg_we_i & (reg_addr_i == `CLVC_A_CMD);

  // set-point path
  wire [9:0] sp_code = sp_cur ? sp_curr_i : sp_volt_i;
  wire [15:0] sp_u = clvc_scale(clvc_norm(sp_code, sp_cur & ctrl[`CLVC_B_SPOFS]), gain);
  wire signed [35:0] sp_two = $signed({19'h00000, sp_u, 1'b0}) - 36'sh007fff;
  wire signed [15:0] sp_s = two ? clvc_sat(sp_two) : sp_u;
  wire [15:0] act_s = clvc_scale(clvc_norm(act_i, ctrl[`CLVC_B_ACTOFS]), gain);

  // ramp generator, 8 fraction bits below the set-point scale
  wire signed [15:0] r_s = ramp_q[23:8];
  wire signed [24:0] tgt = {sp_s[15], sp_s, 8'h00};
  wire [15:0] rup = cfg_q[`CLVC_A_RUP];
  wire [15:0] rdn = cfg_q[`CLVC_A_RDN];
  wire signed [24:0] up_n = ramp_q + $signed({9'h000, rup});
  wire signed [24:0] dn_n = ramp_q - $signed({9'h000, rdn});

  // pid
  wire signed [35:0] e_w = {{20{r_s[15]}}, r_s} - {20'h00000, act_s};
  wire signed [15:0] e_s = clvc_sat(e_w);
  wire signed [35:0] de_w = {{20{e_s[15]}}, e_s} - {{20{e_prev_q[15]}}, e_prev_q};
  wire signed [35:0] p_w = ($signed({1'b0, cfg_q[`CLVC_A_KP]}) * e_s) >>> 6;
  wire signed [35:0] ki_w = ($signed({1'b0, cfg_q[`CLVC_A_KI]}) * e_s) >>> 10;
  wire signed [35:0] d_w = ($signed({1'b0, cfg_q[`CLVC_A_KD]}) * de_w) >>> 6;
  wire signed [35:0] i_w = {{20{integ_q[15]}}, integ_q} + ki_w;
  wire signed [35:0] u_w = p_w + {{20{integ_q[15]}}, integ_q} + d_w;
  wire signed [15:0] pid_s = clvc_sat(u_w);

  // supervision
  wire cb_cond = ctrl[`CLVC_B_CBM] & sp_cur & ctrl[`CLVC_B_SPOFS] &
                 (sp_curr_i < `CLVC_CB_CODE);
  wire sens_err = ctrl[`CLVC_B_ACTOFS] & (act_i < `CLVC_CB_CODE);
  wire cfg_err = ctrl[`CLVC_B_BIPOL] & ~two;
  wire blk_now = cb_q | cfg_err;
  wire err_now = blk_now | sens_err;

  // output stage
  wire signed [15:0] drv = err_lat_q ? cfg_q[`CLVC_A_FIX] : cmd_q;
  wire blocked = ~run | (err_lat_q & (blk_lat_q | ~ctrl[`CLVC_B_REACT]));
  wire [15:0] mag = drv[15] ? (16'h0000 - drv) : drv;
  wire [11:0] cur = mag[15] ? 12'hfff : mag[14:3];
  wire signed [35:0] te_w = {{20{sp_s[15]}}, sp_s} - {20'h00000, act_s};
  wire [35:0] te_abs = te_w[35] ? (36'h000000000 - te_w) : te_w;
  wire tgt_now = te_abs <= {20'h00000, cfg_q[`CLVC_A_WIN]};

  // enable pin: a change counts once the last two stages agree
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      en_q <= 1'b0;
      en_p_q <= 1'b0;
    end else begin
      en_s1_q <= enable_i;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      if (en_s2_q == en_s3_q)
        en_q <= en_s3_q;
      en_p_q <= en_q;
    end
  end

  // break must persist the whole window; output may still move meanwhile
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cb_cnt_q <= 21'h000000;
      cb_q <= 1'b0;
    end else if (!cb_cond) begin
      cb_cnt_q <= 21'h000000;
      cb_q <= 1'b0;
    end else if (cb_cnt_q == CB_LAST) begin
      cb_q <= 1'b1;
    end else begin
      cb_cnt_q <= cb_cnt_q + 21'h000001;
    end
  end

  // set wins over the re-enable clear
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_lat_q <= 1'b0;
      blk_lat_q <= 1'b0;
    end else begin
      if (err_now)
        err_lat_q <= 1'b1;
      else if (en_rise)
        err_lat_q <= 1'b0;
      if (blk_now)
        blk_lat_q <= 1'b1;
      else if (en_rise)
        blk_lat_q <= 1'b0;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rt_cnt_q <= 15'h0000;
      ramp_q <= 25'h0000000;
    end else begin
      rt_cnt_q <= rtick ? 15'h0000 : rt_cnt_q + 15'h0001;
      if (!run) begin
        ramp_q <= 25'h0000000;
      end else if (rtick) begin
        if (ramp_q < tgt)
          ramp_q <= (rup == 16'h0000 || up_n > tgt) ? tgt : up_n;
        else if (ramp_q > tgt)
          ramp_q <= (rdn == 16'h0000 || dn_n < tgt) ? tgt : dn_n;
      end
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      integ_q <= 16'h0000;
      e_prev_q <= 16'h0000;
      cmd_q <= 16'h0000;
    end else if (!run) begin
      integ_q <= 16'h0000;
      e_prev_q <= 16'h0000;
      cmd_q <= 16'h0000;
    end else if (adc_valid_i) begin
      e_prev_q <= e_s;
      integ_q <= clvc_sat(i_w);
      cmd_q <= ctrl[`CLVC_B_LOOP] ? pid_s : r_s;
    end
  end

  // single-solenoid drops the negative half
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sol_a_q <= 12'h000;
      sol_b_q <= 12'h000;
      tgt_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      sol_a_q <= (blocked | drv[15]) ? 12'h000 : cur;
      sol_b_q <= (blocked | ~drv[15] | ~two) ? 12'h000 : cur;
      tgt_q <= tgt_now & run;
      dout_q <= ctrl[`CLVC_B_DMODE] ? tgt_q : err_lat_q;
    end
  end

  always @(posedge clk_i) begin
    if (adc_valid_i & ctrl[`CLVC_B_REC])
      rec_mem[wp_q] <= {sp_s, act_s, e_s, cmd_q};
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      wp_q <= 4'h0;
    else if (adc_valid_i & ctrl[`CLVC_B_REC])
      wp_q <= wp_q + 4'h1;
  end

  // restore runs after every reset; bus writes during a restore may be overwritten
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_LOAD;
      idx_q <= 4'h0;
      nre_q <= 1'b0;
      nwe_q <= 1'b0;
      naddr_q <= 4'h0;
      nwd_q <= 16'h0000;
      ldv_q <= 1'b0;
      ldi_q <= 4'h0;
    end else begin
      nre_q <= 1'b0;
      nwe_q <= 1'b0;
      ldv_q <= nre_q;
      ldi_q <= naddr_q;
      case (st_q)
        ST_IDLE: begin
          idx_q <= 4'h0;
          if (cmd_wr & reg_wdata_i[`CLVC_B_SAVE])
            st_q <= ST_SAVE;
          else if (cmd_wr & reg_wdata_i[`CLVC_B_LOAD])
            st_q <= ST_LOAD;
        end
        ST_LOAD: begin
          nre_q <= 1'b1;
          naddr_q <= idx_q;
          idx_q <= idx_q + 4'h1;
          if (idx_q == `CLVC_LAST_CFG)
            st_q <= ST_IDLE;
        end
        ST_SAVE: begin
          nwe_q <= 1'b1;
          naddr_q <= idx_q;
          nwd_q <= cfg_q[idx_q];
          idx_q <= idx_q + 4'h1;
          if (idx_q == `CLVC_LAST_CFG)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (i = 0; i <= 8; i = i + 1)
        cfg_q[i] <= clvc_rst(i[3:0]);
      ridx_q <= 4'h0;
    end else begin
      if (ldv_q)
        cfg_q[ldi_q] <= nvm_rdata_i;
      else if (cfg_wr)
        cfg_q[reg_addr_i] <= reg_wdata_i;
      if (reg_we_i && reg_addr_i == `CLVC_A_RIDX)
        ridx_q <= reg_wdata_i[3:0];
    end
  end

  always @* begin
    rdata_d = 16'h0000;
    case (reg_addr_i)
      `CLVC_A_STAT: rdata_d = {8'h00, cfg_err, ~st_q[0], en_q, tgt_q, sens_err, cb_q,
                               blk_lat_q, err_lat_q};
      `CLVC_A_CMD: rdata_d = {15'h0000, ~st_q[0]};
      `CLVC_A_RIDX: rdata_d = {12'h000, ridx_q};
      `CLVC_A_REC0: rdata_d = rec_mem[ridx_q][63:48];
      `CLVC_A_REC1: rdata_d = rec_mem[ridx_q][47:32];
      `CLVC_A_REC2: rdata_d = rec_mem[ridx_q][31:16];
      `CLVC_A_REC3: rdata_d = rec_mem[ridx_q][15:0];
      default: rdata_d = cfg_q[reg_addr_i];
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rdata_q <= 16'h0000;
    else
      rdata_q <= reg_re_i ? rdata_d : 16'h0000;
  end

  assign reg_rdata_o = rdata_q;
  assign sol_a_o = sol_a_q;
  assign sol_b_o = sol_b_q;
  assign dout_o = dout_q;
  assign nvm_we_o = nwe_q;
  assign nvm_re_o = nre_q;
  assign nvm_addr_o = naddr_q;
  assign nvm_wdata_o = nwd_q;
endmodule

//--- verif/clvc_ctrl_assertions.sv
// port checker for the valve loop controller
`timescale 1ns/1ps
module clvc_ctrl_assertions #(
  parameter CB_CYC = 20
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  input wire [15:0] reg_rdata_o,
  input wire enable_i,
  input wire [9:0] sp_curr_i,
  input wire [11:0] sol_a_o,
  input wire [11:0] sol_b_o,
  input wire dout_o,
  input wire nvm_we_o,
  input wire nvm_re_o,
  input wire [3:0] nvm_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // mirror of the control word; a restore from memory is not followed, so
  // the mode-dependent checks trust software writes only
  reg [15:0] ctrl_q;
  reg known_q;
  reg [31:0] brk_q;
  reg [7:0] en_q;
  wire brk_w = known_q && ctrl_q[7] && ctrl_q[5] && ctrl_q[4] && sp_curr_i < 10'h066 && !reg_we_i;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= 16'h0000;
      known_q <= 1'b0;
      brk_q <= 32'h0;
      en_q <= 8'h00;
    end else begin
      if (reg_we_i && reg_addr_i == 4'h0) begin
        ctrl_q <= reg_wdata_i;
        known_q <= 1'b1;
      end
      brk_q <= brk_w ? brk_q + 32'h1 : 32'h0;
      en_q <= !enable_i ? 8'h00 : (en_q == 8'hff ? en_q : en_q + 8'h01);
    end
  end
  sequence restore_step;
    nvm_re_o && nvm_addr_o < 4'h8;
  endsequence
  sequence held_off_target;
    (!enable_i && known_q && ctrl_q[1]) [*8];
  endsequence
  chk_read_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  chk_dis_nocur: assert property (!enable_i [*8] |-> sol_a_o == 12'h000 && sol_b_o == 12'h000)
    else $error("current while disabled");
  chk_one_side: assert property (sol_a_o == 12'h000 || sol_b_o == 12'h000)
    else $error("both solenoids driven");
  chk_nvm_excl: assert property (!(nvm_we_o && nvm_re_o))
    else $error("memory read and write together");
  chk_restore_order: assert property (restore_step |=> nvm_re_o && nvm_addr_o == $past(nvm_addr_o) + 4'h1)
    else $error("restore address sequence broken");
  chk_tgt_dis: assert property (held_off_target |-> !dout_o)
    else $error("target indicated while disabled");
  chk_brk_block: assert property (brk_q > CB_CYC + 16 |-> sol_a_o == 12'h000 && sol_b_o == 12'h000)
    else $error("cable break not blocking");
  chk_brk_fault: assert property (brk_q > CB_CYC + 16 && !ctrl_q[1] |-> dout_o)
    else $error("cable break not reported");
  chk_err_hold: assert property (known_q && !ctrl_q[1] && dout_o && en_q > 8'h08 && !reg_we_i
    && !$past(reg_we_i) && !$past(reg_we_i, 2) |=> dout_o)
    else $error("error latch dropped while enabled");
endmodule
bind clvc_ctrl clvc_ctrl_assertions #(.CB_CYC(CB_CYC)) clvc_ctrl_assertions_inst (.clk_i, .rstn_i,
  .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .enable_i, .sp_curr_i, .sol_a_o,
  .sol_b_o, .dout_o, .nvm_we_o, .nvm_re_o, .nvm_addr_o);

//--- verif/clvc_partner.sv
// machine controller, sensor converter and parameter memory beside the controller
`timescale 1ns/1ps
module clvc_partner (
  input wire clk_i,
  input wire rstn_i,
  input wire en_req_i,
  input wire [9:0] spv_req_i,
  input wire [9:0] spc_req_i,
  input wire [9:0] act_req_i,
  output reg enable_o,
  output reg adc_valid_o,
  output reg [9:0] sp_volt_o,
  output reg [9:0] sp_curr_o,
  output reg [9:0] act_o,
  input wire nvm_we_i,
  input wire nvm_re_i,
  input wire [3:0] nvm_addr_i,
  input wire [15:0] nvm_wdata_i,
  output reg [15:0] nvm_rdata_o
);
  // memory is not cleared by reset: it must survive it
  reg [15:0] mem [0:15];
  reg [2:0] tick_q;
  integer i;
  initial begin
    for (i = 0; i < 16; i = i + 1) mem[i] = 16'h0000;
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_o <= 1'b0;
      adc_valid_o <= 1'b0;
      tick_q <= 3'h0;
      nvm_rdata_o <= 16'h0000;
    end else begin
      enable_o <= en_req_i;
      tick_q <= tick_q + 3'h1;
      adc_valid_o <= tick_q == 3'h7;
      if (tick_q == 3'h7) begin
        sp_volt_o <= spv_req_i;
        sp_curr_o <= spc_req_i;
        act_o <= act_req_i;
      end
      if (nvm_we_i) mem[nvm_addr_i] <= nvm_wdata_i;
      // data valid only after a read; otherwise it toggles so stale use shows
      nvm_rdata_o <= nvm_re_i ? mem[nvm_addr_i] : ~nvm_rdata_o;
    end
  end
endmodule

//--- verif/clvc_ctrl_tb_top.sv
// self-checking bench for the valve loop controller
`timescale 1ns/1ps
`include "clvc_consts.vh"
module clvc_ctrl_tb_top;
  reg clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [3:0] reg_addr_i = 4'h0;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg reg_we_i = 1'b0;
  reg reg_re_i = 1'b0;
  reg en = 1'b0;
  reg [9:0] sv = 10'h000;
  reg [9:0] sc = 10'h000;
  reg [9:0] ac = 10'h000;
  wire [15:0] reg_rdata_o;
  wire [11:0] sol_a_o;
  wire [11:0] sol_b_o;
  wire dout_o, enable_i, adc_valid_i, nvm_we_o, nvm_re_o;
  wire [9:0] sp_volt_i, sp_curr_i, act_i;
  wire [3:0] nvm_addr_o;
  wire [15:0] nvm_wdata_o, nvm_rdata_i;
  integer mismatches = 0;
  integer checked = 0;
  reg [15:0] r;
  always #25 clk_i = ~clk_i;
  clvc_ctrl #(.CB_CYC(20), .RAMP_CYC(4)) clvc_ctrl_inst (.clk_i, .rstn_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .enable_i, .adc_valid_i, .sp_volt_i,
    .sp_curr_i, .act_i, .sol_a_o, .sol_b_o, .dout_o, .nvm_we_o, .nvm_re_o, .nvm_addr_o,
    .nvm_wdata_o, .nvm_rdata_i);
  clvc_partner clvc_partner_inst (.clk_i, .rstn_i, .en_req_i(en), .spv_req_i(sv),
    .spc_req_i(sc), .act_req_i(ac), .enable_o(enable_i), .adc_valid_o(adc_valid_i),
    .sp_volt_o(sp_volt_i), .sp_curr_o(sp_curr_i), .act_o(act_i), .nvm_we_i(nvm_we_o),
    .nvm_re_i(nvm_re_o), .nvm_addr_i(nvm_addr_o), .nvm_wdata_i(nvm_wdata_o),
    .nvm_rdata_o(nvm_rdata_i));
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
    end
  endtask
  // a spare cycle after each strobe keeps a strobe from being assigned twice in one step
  task wr(input [3:0] ad, input [15:0] d);
    begin
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rdr(input [3:0] ad);
    begin
      reg_addr_i <= ad;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 r = reg_rdata_o;
      @(posedge clk_i);
    end
  endtask
  task wt;
    integer i;
    begin
      for (i = 0; i < 60; i = i + 1) begin
        rdr(`CLVC_A_CMD);
        if (r[0] === 1'b0) i = 60;
      end
      chk("busy", r[0], 1'b0);
    end
  endtask
  task t_regs;
    begin
      rdr(`CLVC_A_SCALE);
      chk("restore", r, 16'h0000);
      wr(`CLVC_A_KP, 16'h0080);
      rdr(`CLVC_A_KP);
      chk("kp", r, 16'h0080);
      wr(`CLVC_A_SCALE, 16'h0100);
      wr(`CLVC_A_WIN, 16'h0100);
      wr(`CLVC_A_CTRL, 16'h0008);
      cyc(4);
      rdr(`CLVC_A_STAT);
      chk("cfgerr", r[7], 1'b1);
      wr(`CLVC_A_CTRL, 16'h000c);
      cyc(4);
      rdr(`CLVC_A_STAT);
      chk("bipol2", r[7], 1'b0);
    end
  endtask
  task t_amp;
    begin
      wr(`CLVC_A_CTRL, 16'h0004);
      sv <= 10'h3ff;
      en <= 1'b1;
      cyc(24);
      chk("sol_a", sol_a_o, 12'hff8);
      chk("sol_b", sol_b_o, 12'h000);
      sv <= 10'h000;
      cyc(24);
      chk("sol_bn", sol_b_o, 12'hfff);
      wr(`CLVC_A_CTRL, 16'h0014);
      sc <= 10'h3ff;
      cyc(24);
      chk("sp_cur", sol_a_o, 12'hff8);
      en <= 1'b0;
      wr(`CLVC_A_CTRL, 16'h0000);
      wr(`CLVC_A_SCALE, 16'h0080);
      wr(`CLVC_A_RUP, 16'h0100);
      cyc(20);
      chk("dis", sol_a_o | sol_b_o, 12'h000);
      sv <= 10'h3ff;
      en <= 1'b1;
      cyc(40);
      chk("ramp_up", sol_a_o < 12'h064, 1'b1);
      wr(`CLVC_A_RUP, 16'h0000);
      cyc(24);
      chk("scale", sol_a_o, 12'h7fe);
      wr(`CLVC_A_RDN, 16'h0100);
      sv <= 10'h000;
      cyc(40);
      chk("ramp_dn", sol_a_o > 12'h700, 1'b1);
      wr(`CLVC_A_RDN, 16'h0000);
      wr(`CLVC_A_SCALE, 16'h0100);
      en <= 1'b0;
    end
  endtask
  task t_loop;
    begin
      wr(`CLVC_A_CTRL, 16'h0001);
      wr(`CLVC_A_KP, 16'h0040);
      sv <= 10'h3ff;
      ac <= 10'h000;
      en <= 1'b1;
      cyc(24);
      chk("p_full", sol_a_o, 12'hffc);
      ac <= 10'h200;
      cyc(24);
      chk("p_half", sol_a_o, 12'h7fc);
      ac <= 10'h3ff;
      cyc(24);
      chk("p_zero", sol_a_o, 12'h000);
      // integral only: a proportional-only loop would leave the output at half scale
      wr(`CLVC_A_KP, 16'h0000);
      wr(`CLVC_A_KI, 16'h0400);
      ac <= 10'h200;
      cyc(96);
      chk("integ", sol_a_o, 12'hfff);
      wr(`CLVC_A_KI, 16'h0000);
      en <= 1'b0;
      cyc(12);
      en <= 1'b1;
      cyc(24);
      chk("int_rst", sol_a_o, 12'h000);
      en <= 1'b0;
    end
  endtask
  task t_tgt;
    begin
      wr(`CLVC_A_CTRL, 16'h0002);
      sv <= 10'h200;
      ac <= 10'h200;
      en <= 1'b1;
      cyc(24);
      chk("tgt_in", dout_o, 1'b1);
      ac <= 10'h000;
      cyc(24);
      chk("tgt_out", dout_o, 1'b0);
      en <= 1'b0;
      cyc(12);
    end
  endtask
  task t_fault;
    begin
      wr(`CLVC_A_CTRL, 16'h00b0);
      sc <= 10'h3ff;
      en <= 1'b1;
      cyc(24);
      chk("ofs", sol_a_o, 12'hffa);
      sc <= 10'h000;
      cyc(8);
      chk("early", dout_o, 1'b0);
      cyc(48);
      chk("cb_flt", dout_o, 1'b1);
      chk("cb_blk", sol_a_o, 12'h000);
      sc <= 10'h3ff;
      cyc(24);
      chk("latch", dout_o, 1'b1);
      en <= 1'b0;
      cyc(12);
      en <= 1'b1;
      cyc(24);
      chk("clear", dout_o, 1'b0);
      chk("resume", sol_a_o, 12'hffa);
      wr(`CLVC_A_CTRL, 16'h0030);
      sc <= 10'h000;
      cyc(56);
      chk("no_sup", dout_o, 1'b0);
      wr(`CLVC_A_FIX, 16'h4000);
      wr(`CLVC_A_CTRL, 16'h0140);
      sv <= 10'h3ff;
      cyc(24);
      chk("fix", sol_a_o, 12'h800);
      chk("sens", dout_o, 1'b1);
      wr(`CLVC_A_CTRL, 16'h0040);
      cyc(24);
      chk("block", sol_a_o, 12'h000);
      en <= 1'b0;
      ac <= 10'h200;
    end
  endtask
  task t_nvm;
    begin
      wr(`CLVC_A_KP, 16'h0055);
      wr(`CLVC_A_CMD, 16'h0001);
      wt;
      wr(`CLVC_A_KP, 16'h0011);
      wr(`CLVC_A_CMD, 16'h0002);
      wt;
      rdr(`CLVC_A_KP);
      chk("nvm", r, 16'h0055);
    end
  endtask
  // a second reset must bring the saved words back; memory outlives it
  task t_rec;
    begin
      sv <= 10'h200;
      ac <= 10'h100;
      rstn_i <= 1'b0;
      cyc(5);
      rstn_i <= 1'b1;
      cyc(24);
      rdr(`CLVC_A_KP);
      chk("reload", r, 16'h0055);
      wr(`CLVC_A_CTRL, 16'h0200);
      cyc(24);
      wr(`CLVC_A_CTRL, 16'h0000);
      wr(`CLVC_A_RIDX, 16'h0000);
      rdr(`CLVC_A_REC0);
      chk("rec_sp", r, 16'h4000);
      rdr(`CLVC_A_REC1);
      chk("rec_act", r, 16'h2000);
      rdr(`CLVC_A_REC2);
      chk("rec_diff", r, 16'he000);
      rdr(`CLVC_A_REC3);
      chk("rec_cmd", r, 16'h0000);
    end
  endtask
  task summarize;
    begin
      if (mismatches == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6000) @(posedge clk_i);
    mismatches = mismatches + 1;
    summarize;
  end
  initial begin
    cyc(5);
    rstn_i <= 1'b1;
    cyc(40);
    t_regs;
    t_amp;
    t_loop;
    t_tgt;
    t_fault;
    t_nvm;
    t_rec;
    summarize;
  end
endmodule
